/* bench/bmx_matrix_monitor.sv */
/*
 Port checker of the bus matrix.
 Assumes it is bound to bmx_matrix and sees its ports only.
*/
`timescale 1ns/1ns
module bmx_matrix_monitor
   import bmx_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  srst,
   input wire bmx_mreq_type [NM-1:0] m_req,
   input wire bmx_rsp_type [NM-1:0]  m_rsp_r,
   input wire bmx_sreq_type [NS-1:0] s_req_r,
   input wire logic [AW-1:0]         reg_addr,
   input wire logic [31:0]           reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [31:0]           reg_rdata_r,
   input wire logic [SYSIO_W-1:0]    sysio_gpio_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Requests as sampled at the edge that launched the strobe.
   bmx_mreq_type [NM-1:0] prev_r;
   always_ff @(posedge clk) prev_r <= m_req;
   // ==========
   // Slave side
   for (genvar s = 0; s < NS; s++) begin : g_s
      a_hsel_pulse: assert property (s_req_r[s].hsel |=> !s_req_r[s].hsel)
         else $error("select held too long");
      a_path_wired: assert property (s_req_r[s].hsel |-> PATH[s][s_req_r[s].hmaster])
         else $error("unwired path used");
      a_route_addr: assert property (s_req_r[s].hsel |->
         s_req_r[s].req.haddr == prev_r[s_req_r[s].hmaster].haddr)
         else $error("slave address wrong");
   end
   a_decode_sram: assert property (s_req_r[0].hsel |->
      s_req_r[0].req.haddr[31:24] == A_TOP_SRAM) else $error("wrong slave decoded");
   // ==========
   // Master side and registers
   for (genvar m = 0; m < NM; m++) begin : g_m
      a_rsp_pulse: assert property (m_rsp_r[m].hready |=> !m_rsp_r[m].hready)
         else $error("ready held too long");
   end
   a_err_unwired: assert property (m_req[0].htrans[1] && !m_rsp_r[0].hready &&
      m_req[0].haddr[31:24] == A_TOP_SRAM |=> m_rsp_r[0].hready && m_rsp_r[0].hresp)
      else $error("no error for unwired slave");
   a_rd_window: assert property (reg_rdata_r != 32'h0 |-> $past(reg_rd))
      else $error("read data outside its cycle");
   a_sysio_write: assert property (reg_wr && reg_addr == OFF_SYSIO |=>
      sysio_gpio_r == $past(reg_wdata[SYSIO_W-1:0])) else $error("io select not written");
   c_bridge: cover property (s_req_r[S_BRIDGE].hsel && s_req_r[S_BRIDGE].hmaster == 2'h2);
   c_err: cover property (m_rsp_r[0].hready && m_rsp_r[0].hresp);
   c_read: cover property (reg_rd ##1 reg_rdata_r != 32'h0);
endmodule

bind bmx_matrix bmx_matrix_monitor u_mon (.clk(clk), .srst(srst), .m_req(m_req),
   .m_rsp_r(m_rsp_r), .s_req_r(s_req_r), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .sysio_gpio_r(sysio_gpio_r));

/* bench/bmx_slave_model.sv */
/*
 Model of the four slaves behind the matrix.
 Assumes a one-cycle select strobe; wait_cyc adds wait cycles.
*/
`timescale 1ns/1ns
module bmx_slave_model
   import bmx_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   input  wire bmx_sreq_type [NS-1:0] s_req_r,
   input  wire logic [3:0]            wait_cyc,
   output bmx_rsp_type [NS-1:0]       s_rsp
);
   logic [3:0] cnt_r [NS];
   always_ff @(posedge clk) begin
      for (int s = 0; s < NS; s++) begin
         if (srst) begin
            cnt_r[s] <= 4'h0;
         end else if (s_req_r[s].hsel) begin
            cnt_r[s] <= wait_cyc;
         end else if (cnt_r[s] != 4'h0) begin
            cnt_r[s] <= cnt_r[s] - 4'h1;
         end
      end
   end
   // Idle data lines show the inverse, so a stale word never passes for valid.
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         s_rsp[s].hready = (s_req_r[s].hsel && wait_cyc == 4'h0) || cnt_r[s] == 4'h1;
         s_rsp[s].hresp  = 1'b0;
         s_rsp[s].hrdata = {6'h0, 2'(s), s_req_r[s].req.haddr[23:0]} ^ {32{!s_rsp[s].hready}};
      end
   end
endmodule

/* bench/tb.sv */
/*
 Self-checking bench of the bus matrix.
 Assumes the slave model echoes its slave number and low address bits.
*/
`timescale 1ns/1ns
module tb
   import bmx_pkg::*;
;
   logic                  clk = 1'b0;
   logic                  srst = 1'b1;
   bmx_mreq_type [NM-1:0] m_req = '0;
   bmx_rsp_type [NM-1:0]  m_rsp_r;
   bmx_sreq_type [NS-1:0] s_req_r;
   bmx_rsp_type [NS-1:0]  s_rsp;
   logic [AW-1:0]         reg_addr = 9'h000;
   logic [31:0]           reg_wdata = 32'h0;
   logic [31:0]           reg_rdata_r;
   logic                  reg_wr = 1'b0;
   logic                  reg_rd = 1'b0;
   logic [SYSIO_W-1:0]    sysio_gpio_r;
   logic [3:0]            wait_cyc = 4'h0;
   int                    n_errors = 0;
   int                    total_checks = 0;
   logic [31:0]           lat [NM];
   time                   done_t [NM];
   // Rows: master digit, error flag (4) with slave, address.
   localparam logic [39:0] ROWS [12] = '{40'h0_1_00800000, 40'h0_2_00400000,
      40'h0_4_20000000, 40'h0_4_40000000, 40'h0_1_00000000, 40'h1_4_00400000,
      40'h1_3_40000010, 40'h2_0_20000020, 40'h1_0_20000004, 40'h2_2_00400008,
      40'h2_1_00800000, 40'h2_4_60000000};
   always #10 clk = ~clk;
   bmx_matrix DUT (.clk(clk), .srst(srst), .m_req(m_req), .m_rsp_r(m_rsp_r),
      .s_req_r(s_req_r), .s_rsp(s_rsp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .sysio_gpio_r(sysio_gpio_r));
   bmx_slave_model u_slv (.clk(clk), .srst(srst), .s_req_r(s_req_r), .wait_cyc(wait_cyc),
      .s_rsp(s_rsp));
   // ==========
   // Tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_r, exp);
   endtask
   task automatic row(input int m, input logic [31:0] a, input logic e, input logic [1:0] s);
      int i;
      @(posedge clk);
      m_req[m].htrans <= TR_NONSEQ;
      m_req[m].haddr <= a;
      #1;
      for (i = 1; i < 40 && m_rsp_r[m].hready !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      lat[m] = i;
      done_t[m] = $time;
      if (i == 40) begin
         n_errors++;
         print_verdict();
      end
      chk(32'(m_rsp_r[m].hresp), 32'(e));
      if (!e) chk(m_rsp_r[m].hrdata, {6'h0, s, a[23:0]});
      @(posedge clk);
      m_req[m].htrans <= TR_IDLE;
   endtask
   task automatic contest(input logic [31:0] scfg, prio, input logic w);
      wr(OFF_SCFG, scfg);
      wr(OFF_PRAS, prio);
      fork
         row(1, 32'h20000040, 1'b0, S_SRAM);
         row(2, 32'h20000080, 1'b0, S_SRAM);
      join
      chk(32'(done_t[1] < done_t[2]), 32'(w));
   endtask
   // ==========
   // Sequence
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (int s = 0; s < NS; s++) rd(OFF_SCFG + 9'(SCFG_STEP * s), SCFG_RST[s]);
      rd(OFF_PRAS, 32'h0);
      wr(9'h1fc, 32'hffffffff);
      rd(9'h1fc, 32'h0);
      wr(OFF_MCFG + 9'h004, {29'h0, SPLIT_16});
      rd(OFF_MCFG + 9'h004, 32'h4);
      wr(OFF_SYSIO, 32'h0000a5c3);
      chk(32'(sysio_gpio_r), 32'h0000a5c3);
      rd(OFF_SYSIO, 32'h0000a5c3);
      $display("test registers done");
      foreach (ROWS[k]) row(int'(ROWS[k][37:36]), ROWS[k][31:0], ROWS[k][34], ROWS[k][33:32]);
      wr(OFF_REMAP, 32'h1);
      row(2, 32'h00000000, 1'b0, S_FLASH);
      fork
         row(1, 32'h40000000, 1'b0, S_BRIDGE);
         row(0, 32'h00800004, 1'b0, S_ROM);
      join
      chk(32'(done_t[0] == done_t[1]), 32'h1);
      $display("test decode done");
      repeat (2) begin
         row(2, 32'h40000020, 1'b0, S_BRIDGE);
         chk(lat[2], 32'h4);
      end
      row(1, 32'h20000000, 1'b0, S_SRAM);
      row(1, 32'h20000008, 1'b0, S_SRAM);
      chk(lat[1], 32'h3);
      row(2, 32'h2000000c, 1'b0, S_SRAM);
      chk(lat[2], 32'h4);
      wr(OFF_SCFG + 9'h008, 32'h00020010);
      row(2, 32'h00400010, 1'b0, S_FLASH);
      chk(lat[2], 32'h4);
      row(0, 32'h00400014, 1'b0, S_FLASH);
      chk(lat[0], 32'h3);
      wait_cyc <= 4'h3;
      row(0, 32'h00400018, 1'b0, S_FLASH);
      chk(lat[0], 32'h6);
      wait_cyc <= 4'h0;
      rd(OFF_SCFG + 9'h008, 32'h00020010);
      $display("test latency done");
      contest(32'h00000010, 32'h0, 1'b1);
      contest(32'h01000010, 32'h0, 1'b0);
      contest(32'h01000010, 32'h00000030, 1'b1);
      $display("test arbitration done");
      print_verdict();
   end
endmodule

/* logic/bmx_arbiter.sv */
/*
 One slave arbiter: grant choice, default master, burst locking and slot limit.
 Assumes the matrix starts a transfer only from the granted master.
*/
`timescale 1ns/1ns
module bmx_arbiter
   import bmx_pkg::*;
#(
   parameter logic [NM-1:0] WIRED = 3'h7
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire bmx_scfg_type      cfg,
   input  wire logic [NM*PR_W-1:0] prio,
   input  wire logic [NM-1:0]     req,
   input  wire logic              start,
   input  wire logic [1:0]        start_trans,
   input  wire logic [2:0]        start_burst,
   input  wire logic [2:0]        split,
   input  wire logic              done,
   output logic                   gnt_v_r,
   output logic [1:0]             gnt_idx_r
);

   // ==========================================================
   // Helpers
   function automatic logic [4:0] burst_len(input logic [2:0] hb, input logic [2:0] sp);
      case (hb)
         BU_SINGLE: burst_len = 5'h01;
         BU_INCR: begin
            case (sp)
               SPLIT_BEAT: burst_len = 5'h01;
               SPLIT_4:    burst_len = 5'h04;
               SPLIT_8:    burst_len = 5'h08;
               SPLIT_16:   burst_len = 5'h10;
               default:    burst_len = 5'h00;
            endcase
         end
         3'h2, 3'h3: burst_len = 5'h04;
         3'h4, 3'h5: burst_len = 5'h08;
         default:    burst_len = 5'h10;
      endcase
   endfunction

   logic [1:0]        rr_ptr_r;
   logic              inflight_r;
   logic              locked_r;
   logic [4:0]        len_r;
   logic [4:0]        beat_r;
   logic [SLOT_W-1:0] slot_r;
   logic [1:0]        pick;
   logic              rearb_ok;
   logic              new_chunk;
   logic              expired;
   logic              found;

   // ==========================================================
   // Choice among requesters
   always_comb begin
      logic [1:0] idx;
      logic [PR_W-1:0] best;
      idx   = 2'h0;
      best  = '0;
      found = 1'b0;
      pick  = 2'h0;
      if (cfg.arb_fixed) begin
         for (int i = 0; i < NM; i++) begin
            if (req[i] && (!found || prio[i*PR_W +: PR_W] >= best)) begin
               found = 1'b1;
               best  = prio[i*PR_W +: PR_W];
               pick  = 2'(i);
            end
         end
      end else begin
         for (int k = NM; k >= 1; k--) begin
            idx = 2'((32'(rr_ptr_r) + k) % NM);
            if (req[idx]) begin
               found = 1'b1;
               pick  = idx;
            end
         end
      end
   end

   assign new_chunk = start && (start_trans == TR_NONSEQ || !locked_r);
   assign expired   = (cfg.slot != '0) && (slot_r == '0);
   assign rearb_ok  = !inflight_r && !start && (!locked_r || !req[gnt_idx_r]);

   // ==========================================================
   // Transfer tracking and burst locking
   always_ff @(posedge clk) begin
      if (srst) begin
         inflight_r <= 1'b0;
      end else if (start) begin
         inflight_r <= 1'b1;
      end else if (done) begin
         inflight_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         locked_r <= 1'b0;
         len_r    <= 5'h00;
         beat_r   <= 5'h00;
      end else if (new_chunk) begin
         len_r    <= burst_len(start_burst, split);
         beat_r   <= 5'h00;
         locked_r <= burst_len(start_burst, split) != 5'h01;
      end else if (done) begin
         beat_r <= beat_r + 5'h01;
         if ((len_r != 5'h00 && beat_r + 5'h01 == len_r) || expired) begin
            locked_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         slot_r <= '0;
      end else if (new_chunk) begin
         slot_r <= cfg.slot;
      end else if (slot_r != '0) begin
         slot_r <= slot_r - 1'b1;
      end
   end

   // ==========================================================
   // Grant and default master
   always_ff @(posedge clk) begin
      if (srst) begin
         gnt_v_r   <= 1'b0;
         gnt_idx_r <= 2'h0;
         rr_ptr_r  <= 2'(NM - 1);
      end else if (rearb_ok) begin
         if (found) begin
            gnt_v_r   <= 1'b1;
            gnt_idx_r <= pick;
            rr_ptr_r  <= pick;
         end else begin
            case (cfg.kind)
               DM_NONE:  gnt_v_r <= 1'b0;
               DM_LAST:  gnt_v_r <= gnt_v_r;
               DM_FIXED: begin
                  gnt_v_r   <= cfg.pinned < 4'(NM) && WIRED[cfg.pinned[1:0]];
                  gnt_idx_r <= cfg.pinned[1:0];
               end
               default:  gnt_v_r <= 1'b0;
            endcase
         end
      end
   end

endmodule

/* logic/bmx_matrix.sv */
/*
 Bus matrix top: per-master decoders, per-slave arbiters, routing and registers.
 Assumes masters hold a request until they see ready, and slaves answer with ready.
*/
`timescale 1ns/1ns
module bmx_matrix
   import bmx_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire bmx_mreq_type [NM-1:0]   m_req,
   output bmx_rsp_type [NM-1:0]         m_rsp_r,
   output bmx_sreq_type [NS-1:0]        s_req_r,
   input  wire bmx_rsp_type [NS-1:0]    s_rsp,
   input  wire logic [AW-1:0]           reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic [31:0]                  reg_rdata_r,
   output logic [SYSIO_W-1:0]           sysio_gpio_r
);

   // ==========================================================
   // Helpers
   function automatic logic [2:0] decode(input logic [31:0] a, input logic boot_flash);
      decode = 3'h0;
      case (a[31:24])
         A_TOP_BOOT: begin
            case (a[23:22])
               A_SUB_WIN:   decode = {1'b1, boot_flash ? S_FLASH : S_ROM};
               A_SUB_FLASH: decode = {1'b1, S_FLASH};
               A_SUB_ROM:   decode = {1'b1, S_ROM};
               default:     decode = 3'h0;
            endcase
         end
         A_TOP_SRAM:   decode = {1'b1, S_SRAM};
         A_TOP_BRIDGE: decode = {1'b1, S_BRIDGE};
         default:      decode = 3'h0;
      endcase
   endfunction

   function automatic bmx_scfg_type unpack_scfg(input logic [31:0] w);
      unpack_scfg.arb_fixed = w[SC_ARB];
      unpack_scfg.pinned    = w[SC_PIN +: 4];
      unpack_scfg.kind      = bmx_dm_type'(w[SC_KIND +: 2]);
      unpack_scfg.slot      = w[SC_SLOT +: SLOT_W];
   endfunction

   function automatic logic [31:0] pack_scfg(input bmx_scfg_type c);
      pack_scfg                   = '0;
      pack_scfg[SC_ARB]           = c.arb_fixed;
      pack_scfg[SC_PIN +: 4]      = c.pinned;
      pack_scfg[SC_KIND +: 2]     = c.kind;
      pack_scfg[SC_SLOT +: SLOT_W] = c.slot;
   endfunction

   // ==========================================================
   // Registers and state
   logic [NM-1:0][2:0]        mcfg_r;
   bmx_scfg_type [NS-1:0]     scfg_r;
   logic [NS-1:0][NM*PR_W-1:0] prio_r;
   logic                      boot_flash_r;
   logic [NM-1:0]             m_wait_r;
   logic [NS-1:0]             busy_r;
   logic [NS-1:0][1:0]        owner_r;

   // ==========================================================
   // Combinational routing terms
   logic [NM-1:0][2:0]        dec;
   logic [NM-1:0]             raw;
   logic [NM-1:0]             mvalid;
   logic [NM-1:0]             path_ok;
   logic [NM-1:0]             err_go;
   logic [NM-1:0]             launched;
   logic [NS-1:0][NM-1:0]     areq;
   logic [NS-1:0]             start;
   logic [NS-1:0]             done;
   logic [NS-1:0]             gnt_v;
   logic [NS-1:0][1:0]        gnt_idx;
   bmx_rsp_type [NM-1:0]      m_rsp_nxt;
   logic [31:0]               rd_nxt;

   // ==========================================================
   // Decoding, one decoder per master
   always_comb begin
      for (int m = 0; m < NM; m++) begin
         dec[m]     = decode(m_req[m].haddr, boot_flash_r);
         raw[m]     = m_req[m].htrans[1];
         mvalid[m]  = raw[m] && !m_wait_r[m] && !m_rsp_r[m].hready;
         path_ok[m] = dec[m][2] && PATH[dec[m][1:0]][m];
         err_go[m]  = mvalid[m] && !path_ok[m];
      end
   end

   // Requests to each arbiter use the raw request so that a burst owner
   // still counts as requesting in the cycle its answer is returned.
   always_comb begin
      launched = '0;
      for (int s = 0; s < NS; s++) begin
         for (int m = 0; m < NM; m++) begin
            areq[s][m] = raw[m] && path_ok[m] && dec[m][1:0] == 2'(s);
         end
         start[s] = !busy_r[s] && gnt_v[s] && areq[s][gnt_idx[s]]
                    && mvalid[gnt_idx[s]];
         done[s]  = busy_r[s] && s_rsp[s].hready;
         if (start[s]) begin
            launched[gnt_idx[s]] = 1'b1;
         end
      end
   end

   // ==========================================================
   // Arbiters, one per slave
   for (genvar s = 0; s < NS; s++) begin : g_arb
      bmx_arbiter #(
         .WIRED(PATH[s])
      ) u_arb (
         .clk        (clk),
         .srst       (srst),
         .cfg        (scfg_r[s]),
         .prio       (prio_r[s]),
         .req        (areq[s]),
         .start      (start[s]),
         .start_trans(m_req[gnt_idx[s]].htrans),
         .start_burst(m_req[gnt_idx[s]].hburst),
         .split      (mcfg_r[gnt_idx[s]]),
         .done       (done[s]),
         .gnt_v_r    (gnt_v[s]),
         .gnt_idx_r  (gnt_idx[s])
      );
   end

   // ==========================================================
   // Slave side: address phase is held for one cycle only.
   always_ff @(posedge clk) begin
      for (int s = 0; s < NS; s++) begin
         if (srst) begin
            s_req_r[s] <= '0;
         end else if (start[s]) begin
            s_req_r[s].hsel    <= 1'b1;
            s_req_r[s].hmaster <= gnt_idx[s];
            s_req_r[s].req     <= m_req[gnt_idx[s]];
         end else begin
            s_req_r[s].hsel       <= 1'b0;
            s_req_r[s].req.htrans <= TR_IDLE;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int s = 0; s < NS; s++) begin
         if (srst) begin
            busy_r[s]  <= 1'b0;
            owner_r[s] <= 2'h0;
         end else if (start[s]) begin
            busy_r[s]  <= 1'b1;
            owner_r[s] <= gnt_idx[s];
         end else if (done[s]) begin
            busy_r[s] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Master side answers
   always_comb begin
      for (int m = 0; m < NM; m++) begin
         m_rsp_nxt[m] = '0;
         for (int s = 0; s < NS; s++) begin
            if (done[s] && owner_r[s] == 2'(m)) begin
               m_rsp_nxt[m] = s_rsp[s];
               m_rsp_nxt[m].hready = 1'b1;
            end
         end
         if (err_go[m]) begin
            m_rsp_nxt[m].hready = 1'b1;
            m_rsp_nxt[m].hresp  = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         m_rsp_r <= '0;
      end else begin
         m_rsp_r <= m_rsp_nxt;
      end
   end

   always_ff @(posedge clk) begin
      for (int m = 0; m < NM; m++) begin
         if (srst) begin
            m_wait_r[m] <= 1'b0;
         end else if (launched[m]) begin
            m_wait_r[m] <= 1'b1;
         end else if (m_rsp_nxt[m].hready) begin
            m_wait_r[m] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Register writes
   // Config changes take effect at once; software should not retune a
   // slave in the middle of a burst it cares about.
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int m = 0; m < NM; m++) begin
            mcfg_r[m] <= MCFG_RST;
         end
         for (int s = 0; s < NS; s++) begin
            scfg_r[s] <= unpack_scfg(SCFG_RST[s]);
            prio_r[s] <= PRAS_RST;
         end
      end else if (reg_wr) begin
         for (int m = 0; m < NM; m++) begin
            if (reg_addr == AW'(OFF_MCFG + MCFG_STEP * m)) begin
               mcfg_r[m] <= reg_wdata[MC_SPLIT +: 3];
            end
         end
         for (int s = 0; s < NS; s++) begin
            if (reg_addr == AW'(OFF_SCFG + SCFG_STEP * s)) begin
               scfg_r[s] <= unpack_scfg(reg_wdata);
            end
            if (reg_addr == AW'(OFF_PRAS + PRAS_STEP * s)) begin
               for (int m = 0; m < NM; m++) begin
                  prio_r[s][m*PR_W +: PR_W] <= reg_wdata[m*PR_STRIDE +: PR_W];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         boot_flash_r <= REMAP_RST;
         sysio_gpio_r <= SYSIO_RST;
      end else if (reg_wr) begin
         if (reg_addr == OFF_REMAP) begin
            boot_flash_r <= reg_wdata[RM_BOOT];
         end
         if (reg_addr == OFF_SYSIO) begin
            sysio_gpio_r <= reg_wdata[SYSIO_W-1:0];
         end
      end
   end

   // ==========================================================
   // Register reads, answered in the next cycle; holes read zero.
   always_comb begin
      rd_nxt = '0;
      for (int m = 0; m < NM; m++) begin
         if (reg_addr == AW'(OFF_MCFG + MCFG_STEP * m)) begin
            rd_nxt[MC_SPLIT +: 3] = mcfg_r[m];
         end
      end
      for (int s = 0; s < NS; s++) begin
         if (reg_addr == AW'(OFF_SCFG + SCFG_STEP * s)) begin
            rd_nxt = pack_scfg(scfg_r[s]);
         end
         if (reg_addr == AW'(OFF_PRAS + PRAS_STEP * s)) begin
            for (int m = 0; m < NM; m++) begin
               rd_nxt[m*PR_STRIDE +: PR_W] = prio_r[s][m*PR_W +: PR_W];
            end
         end
         if (reg_addr == OFF_STATUS) begin
            rd_nxt[3*s +: 3]    = {gnt_v[s], gnt_idx[s]};
            rd_nxt[ST_BUSY + s] = busy_r[s];
         end
      end
      if (reg_addr == OFF_REMAP) begin
         rd_nxt[RM_BOOT] = boot_flash_r;
      end
      if (reg_addr == OFF_SYSIO) begin
         rd_nxt[SYSIO_W-1:0] = sysio_gpio_r;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata_r <= '0;
      end else if (reg_rd) begin
         reg_rdata_r <= rd_nxt;
      end else begin
         reg_rdata_r <= '0;
      end
   end

endmodule

/* logic/bmx_pkg.sv */
/*
 Shared constants, types and the register map of the three-master, four-slave bus matrix.
 Assumes one 50 MHz clock and a synchronous active-high reset in every user.
*/
// Notes on behaviour
// - Three masters 0..2 reach different slaves at the same time.
// - Each master has its own decoder; all decoders share one map.
// - Four slaves 0..3, each with its own separately configured arbiter.
// - Paths: master 0 to slaves 1,2; master 1 to 0,3; master 2 to all.
// - A boot window can map to either of two slaves.
// - Kind none: idle slave disconnects from every master.
// - Kind last: idle slave stays with the most recent requester.
// - Kind fixed: idle slave connects to its pinned master.
// - Pinned master changes only by a software write.
// - Slave config holds 2-bit default kind and 4-bit pinned select.
// - Round-robin or fixed priority per slave; round-robin after reset.
// - Re-arbitrate only when idle, single, burst end, or slot expiry.
// - Undefined-length bursts end predicted per master split setting.
// - Slot counter loads at burst start, counts down, breaks at zero.
// - Round-robin grants lowest master first, then rotates.
// - No default master costs one arbitration cycle per burst.
// - Last master gets zero latency; others one cycle.
// - Fixed default master gets zero latency; others one cycle.
// - Fixed priority: highest value wins, ties to highest master number.
// - Software sets a priority for every master at every slave.
// - System I/O select alone chooses system or GPIO per pin.
// - Split codes: 0 never, 1 every beat, 2/3/4 four/eight/sixteen beats.
// - A slot limit of zero disables slot breaking.
package bmx_pkg;

   // ==========================================================
   // Sizes
   localparam int NM      = 3;
   localparam int NS      = 4;
   localparam int AW      = 9;
   localparam int SYSIO_W = 16;
   localparam int SLOT_W  = 8;
   localparam int PR_W    = 2;

   // ==========================================================
   // Encodings
   typedef enum logic [1:0] {
      DM_NONE  = 2'b00,
      DM_LAST  = 2'b01,
      DM_FIXED = 2'b10
   } bmx_dm_type;
   localparam logic [2:0] SPLIT_NEVER = 3'h0;
   localparam logic [2:0] SPLIT_BEAT  = 3'h1;
   localparam logic [2:0] SPLIT_4     = 3'h2;
   localparam logic [2:0] SPLIT_8     = 3'h3;
   localparam logic [2:0] SPLIT_16    = 3'h4;
   localparam logic [1:0] TR_IDLE     = 2'h0;
   localparam logic [1:0] TR_NONSEQ   = 2'h2;
   localparam logic [2:0] BU_SINGLE   = 3'h0;
   localparam logic [2:0] BU_INCR     = 3'h1;

   // ==========================================================
   // Address map seen by every master decoder
   localparam logic [7:0] A_TOP_BOOT   = 8'h00;
   localparam logic [7:0] A_TOP_SRAM   = 8'h20;
   localparam logic [7:0] A_TOP_BRIDGE = 8'h40;
   localparam logic [1:0] A_SUB_WIN    = 2'h0;
   localparam logic [1:0] A_SUB_FLASH  = 2'h1;
   localparam logic [1:0] A_SUB_ROM    = 2'h2;
   localparam logic [1:0] S_SRAM       = 2'h0;
   localparam logic [1:0] S_ROM        = 2'h1;
   localparam logic [1:0] S_FLASH      = 2'h2;
   localparam logic [1:0] S_BRIDGE     = 2'h3;
   localparam logic [NS-1:0][NM-1:0] PATH = {3'b110, 3'b101, 3'b101, 3'b110};

   // ==========================================================
   // Register offsets, fields and reset values
   localparam logic [AW-1:0] OFF_MCFG   = 9'h000;
   localparam logic [AW-1:0] OFF_SCFG   = 9'h040;
   localparam logic [AW-1:0] OFF_PRAS   = 9'h080;
   localparam logic [AW-1:0] OFF_REMAP  = 9'h100;
   localparam logic [AW-1:0] OFF_SYSIO  = 9'h114;
   localparam logic [AW-1:0] OFF_STATUS = 9'h120;
   localparam int MCFG_STEP  = 4;
   localparam int SCFG_STEP  = 4;
   localparam int PRAS_STEP  = 8;
   localparam int MC_SPLIT   = 0;
   localparam int SC_SLOT    = 0;
   localparam int SC_KIND    = 16;
   localparam int SC_PIN     = 18;
   localparam int SC_ARB     = 24;
   localparam int PR_STRIDE  = 4;
   localparam int RM_BOOT    = 0;
   localparam int ST_BUSY    = 12;
   localparam logic [2:0] MCFG_RST = 3'h0;
   localparam logic [NS-1:0][31:0] SCFG_RST =
      {32'h00000010, 32'h00000010, 32'h00050010, 32'h00010010};
   localparam logic [NM*PR_W-1:0] PRAS_RST  = 6'h00;
   localparam logic [SYSIO_W-1:0] SYSIO_RST = 16'h0000;
   localparam logic               REMAP_RST = 1'b0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [1:0]  htrans;
      logic [31:0] haddr;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [2:0]  hburst;
      logic [31:0] hwdata;
   } bmx_mreq_type;
   typedef struct packed {
      logic        hready;
      logic        hresp;
      logic [31:0] hrdata;
   } bmx_rsp_type;
   typedef struct packed {
      logic        hsel;
      logic [1:0]  hmaster;
      bmx_mreq_type req;
   } bmx_sreq_type;
   typedef struct packed {
      logic              arb_fixed;
      logic [3:0]        pinned;
      bmx_dm_type        kind;
      logic [SLOT_W-1:0] slot;
   } bmx_scfg_type;

endpackage
